/* File: spc_pkg.sv */
// Shared constants, modes and carrier types of the sleep, power and reset controller
package spc_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [11:0] IDX_SLEEP_MODE_CONTROL = 12'h033;
   localparam logic [11:0] IDX_MCU_CONTROL = 12'h035;
   localparam logic [11:0] IDX_PERIPHERAL_CLOCK_GATE = 12'h064;
   localparam logic [11:0] ADDR_SLEEP_MODE_CONTROL = 12'(IDX_SLEEP_MODE_CONTROL * 4);
   localparam logic [11:0] ADDR_MCU_CONTROL = 12'(IDX_MCU_CONTROL * 4);
   localparam logic [11:0] ADDR_PERIPHERAL_CLOCK_GATE = 12'(IDX_PERIPHERAL_CLOCK_GATE * 4);

   // Reset values
   localparam logic [7:0] RST_SLEEP_MODE_CONTROL = 8'h00;
   localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_CLOCK_GATE = 8'h00;

   // Implemented bits; all others read as zero, except MCU control sleep-off and unlock bits 6 and 5
   localparam logic [7:0] MASK_SLEEP_MODE_CONTROL = 8'h0F;
   localparam logic [7:0] MASK_MCU_CONTROL = 8'h13;
   localparam logic [7:0] MASK_PERIPHERAL_CLOCK_GATE = 8'hEF;

   // Sleep mode control fields
   localparam int unsigned SLEEP_ARM_BIT = 0;
   localparam int unsigned SLEEP_MODE_LSB = 1;
   localparam int unsigned SLEEP_MODE_MSB = 3;

   // MCU control fields
   localparam int unsigned BROWNOUT_SLEEP_OFF_BIT = 6;
   localparam int unsigned BROWNOUT_SLEEP_UNLOCK_BIT = 5;

   // Peripheral clock gate fields
   localparam int unsigned TWO_WIRE_GATE_BIT = 7;
   localparam int unsigned TIMER_TWO_GATE_BIT = 6;
   localparam int unsigned TIMER_ZERO_GATE_BIT = 5;
   localparam int unsigned TIMER_ONE_GATE_BIT = 3;
   localparam int unsigned SERIAL_PERIPH_GATE_BIT = 2;
   localparam int unsigned SERIAL_PORT_GATE_BIT = 1;
   localparam int unsigned CONVERTER_GATE_BIT = 0;

   // Timing counts in clock cycles
   localparam logic [2:0] BROWNOUT_SLEEP_OFF_UNLOCK_CYCLES = 3'h4;
   localparam logic [2:0] BROWNOUT_SLEEP_OFF_EFFECT_CYCLES = 3'h3;
   localparam logic [2:0] BROWNOUT_SLEEP_OFF_CLEAR_CYCLES = 3'h3;
   localparam logic [23:0] STANDBY_WAKE_CYCLES = 24'h00_0006;

   // Sleep mode select encodings
   typedef enum logic [2:0] {
      MODE_IDLE = 3'h0,
      MODE_NOISE_REDUCTION = 3'h1,
      MODE_POWER_DOWN = 3'h2,
      MODE_POWER_SAVE = 3'h3,
      MODE_RESERVED_4 = 3'h4,
      MODE_RESERVED_5 = 3'h5,
      MODE_STANDBY = 3'h6,
      MODE_EXT_STANDBY = 3'h7
   } spc_mode_e;

   // Clock domain enables
   typedef struct packed {
      logic cpu;
      logic io;
      logic adc;
      logic async_timer;
      logic main_osc;
   } spc_clk_en_s;

   // Peripheral run enables
   typedef struct packed {
      logic two_wire;
      logic timer_two;
      logic timer_zero;
      logic timer_one;
      logic serial_periph;
      logic serial_port;
      logic converter_powered;
      logic comparator_mux;
   } spc_periph_s;
endpackage

/* File: spc_brownout_sleep_off_seq.sv */
// Timed unlock sequence and self-clearing brown-out sleep-off bit
`timescale 1ns/1ns
module spc_brownout_sleep_off_seq (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic soft_rst, // Internal reset
   input wire logic wr_stb, // Write strobe
   input wire logic wr_off, // Written sleep-off value
   input wire logic wr_unlock, // Written unlock value
   output logic off_bit, // Sleep-off bit readback
   output logic unlock_bit, // Unlock bit readback
   output logic off_active // Sleep-off effective
);
   typedef struct packed {
      logic [2:0] window;
      logic unlock;
      logic off;
      logic [2:0] age;
   } spc_brownout_sleep_off_s;

   spc_brownout_sleep_off_s s_r;
   spc_brownout_sleep_off_s s_nxt;

   // Window countdown, bit aging, write sequence
   always_comb begin
      s_nxt = s_r;
      if (s_r.window != 3'h0) begin
         s_nxt.window = s_r.window - 3'h1; // R05
      end
      s_nxt.unlock = (s_nxt.window != 3'h0);
      if (s_r.off) begin
         s_nxt.age = s_r.age + 3'h1;
         if (s_r.age == spc_pkg::BROWNOUT_SLEEP_OFF_EFFECT_CYCLES + spc_pkg::BROWNOUT_SLEEP_OFF_CLEAR_CYCLES - 3'h1) begin
            s_nxt.off = 1'b0; // R08
            s_nxt.age = 3'h0;
         end
      end
      if (wr_stb) begin
         if (wr_off && wr_unlock) begin
            s_nxt.window = spc_pkg::BROWNOUT_SLEEP_OFF_UNLOCK_CYCLES; // R05
            s_nxt.unlock = 1'b1;
         end else if (wr_off && !wr_unlock && s_r.window != 3'h0 && !s_r.off) begin
            s_nxt.off = 1'b1; // R05
            s_nxt.age = 3'h0;
            s_nxt.window = 3'h0;
            s_nxt.unlock = 1'b0;
         end else if (!wr_unlock) begin
            // Any other write with the unlock bit clear closes the window so a stray write cannot arm later
            s_nxt.window = 3'h0;
            s_nxt.unlock = 1'b0;
         end
      end
      if (soft_rst) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign off_bit = s_r.off;
   assign unlock_bit = s_r.unlock;
   assign off_active = s_r.off && (s_r.age >= spc_pkg::BROWNOUT_SLEEP_OFF_EFFECT_CYCLES); // R06
endmodule

/* File: spc_rst_stretch.sv */
// Delay counter stretching the internal reset
`timescale 1ns/1ns
module spc_rst_stretch #(
   parameter int unsigned CNT_W = 24 // Counter width
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic rst_req, // Combined reset request, level
   input wire logic [CNT_W-1:0] delay_cycles, // Stretch length in cycles
   output logic rst_hold // Internal reset, active high
);
   typedef struct packed {
      logic hold;
      logic [CNT_W-1:0] cnt;
   } spc_stretch_s;

   spc_stretch_s s_r;
   spc_stretch_s s_nxt;

   // Any request restarts the count; release after delay_cycles quiet cycles
   always_comb begin
      s_nxt = s_r;
      if (rst_req) begin
         s_nxt.hold = 1'b1; // R25
         s_nxt.cnt = '0;
      end else if (s_r.hold) begin
         if (s_r.cnt + CNT_W'(1) >= delay_cycles) begin
            s_nxt.hold = 1'b0; // R21
         end else begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{hold: 1'b1, cnt: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rst_hold = s_r.hold;
endmodule

/* File: spc_power_ctrl.sv */
// Sleep, clock gating and reset control behind APB
`timescale 1ns/1ns
// What this block does
// R01 - Sleep control upper four bits read zero
// R02 - Decode three-bit sleep mode select field
// R03 - Sleep instruction sleeps only when armed
// R04 - Software arms just before sleep, disarms after
// R05 - Two-write unlock sets brown-out sleep-off
// R06 - Sleep-off effective three cycles after set
// R07 - Detector off only if sleeping while active
// R08 - Sleep-off clears itself three cycles later
// R09 - Two-wire gate bit stops its clock
// R10 - Timer two gate stops only synchronous mode
// R11 - Timer zero and one gates freeze timers
// R12 - Serial peripheral gate bit stops its clock
// R13 - Serial port gate bit stops its clock
// R14 - Converter gate shuts converter, blocks comparator mux
// R15 - Reserved gate bit reads zero
// R16 - Input buffers off when io, converter clocks stop
// R17 - Watchdog keeps running in every sleep
// R18 - Debug fuse keeps main clock in sleep
// R19 - Reset loads registers, core starts at vector
// R20 - Ports reset at once without a clock; watchdog reaches ports through its registered pulse
// R21 - Fuse-selected delay stretches internal reset
// R22 - Four reset sources assert reset
// R23 - Watchdog reset is one-cycle pulse
// R24 - Standby modes resume six cycles after wake
// R25 - Reset request is OR, reasserting restarts stretch
module spc_power_ctrl #(
   parameter int unsigned CNT_W = 24, // Counter width
   parameter logic [CNT_W-1:0] DELAY_RC_CYCLES = 24'h00_4000, // Base delay, RC clock
   parameter logic [CNT_W-1:0] DELAY_XTAL_CYCLES = 24'h00_8000, // Base delay, crystal
   parameter logic [7:0] EXT_MIN_CYCLES = 8'h04 // Pin low cycles for reset
) (
   input wire logic pclk, // System clock, 250 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic sleep_instr, // Sleep instruction pulse
   input wire logic wake_event, // Wake-up level
   input wire logic timer_two_async_select, // Timer two async clock
   input wire logic debug_enable_fuse, // On-chip debug enabled
   input wire logic [1:0] startup_time_fuse, // Start-up time fuse
   input wire logic [3:0] clock_select_fuse, // Clock select fuse
   input wire logic por_detect, // Power-on detect
   input wire logic ext_reset_pin_n, // Reset pin, active low
   input wire logic wdt_timeout, // Watchdog expiry
   input wire logic wdt_system_mode, // Watchdog in system reset mode
   input wire logic brownout_detect, // Brown-out detect
   input wire logic brownout_fuse_en, // Detector fuse
   output logic port_reset_n, // Port reset
   output logic core_reset_n, // Internal reset
   output logic cpu_asleep, // Core held in sleep
   output logic brownout_detector_en, // Detector powered
   output logic input_buf_en, // Digital input buffers enabled
   output spc_pkg::spc_clk_en_s clk_en, // Clock domain enables
   output spc_pkg::spc_periph_s periph_en // Peripheral run enables
);
   typedef enum logic [1:0] {
      ST_ACTIVE,
      ST_ASLEEP,
      ST_WAKING
   } spc_state_e;

   typedef struct packed {
      logic [3:0] sleep_ctrl;
      logic [2:0] mcu_misc;
      logic [7:0] gate;
      logic [31:0] rdata;
      logic slverr;
      spc_state_e state;
      spc_pkg::spc_mode_e mode;
      logic bod_off;
      logic [CNT_W-1:0] wake_cnt;
      logic [7:0] ext_cnt;
      logic wdt_prev;
      logic wdt_pulse;
      spc_pkg::spc_clk_en_s clk;
      spc_pkg::spc_periph_s periph;
      logic in_buf;
      logic bod_en;
   } spc_ctrl_s;

   spc_ctrl_s s_r;
   spc_ctrl_s s_nxt;

   logic soft_rst;
   logic rst_req;
   logic ext_req;
   logic bod_req;
   logic off_bit;
   logic unlock_bit;
   logic off_active;
   logic setup_phase;
   logic access_wr;
   logic wr_mcu;
   logic [CNT_W-1:0] delay_cycles;
   logic [7:0] sleep_rd;
   logic [7:0] mcu_rd;
   logic [7:0] gate_rd;
   logic core_reset_n_hold;

   // Read data taken in setup so access answers at once
   assign setup_phase = psel && !penable;
   assign access_wr = psel && penable && pwrite;
   assign wr_mcu = access_wr && (paddr == spc_pkg::ADDR_MCU_CONTROL);
   assign pready = psel && penable;
   assign prdata = s_r.rdata;
   assign pslverr = s_r.slverr && psel && penable;

   // Crystal clocks need a longer base; start-up fuse scales it by powers of two
   assign delay_cycles = (clock_select_fuse[3] ? DELAY_XTAL_CYCLES : DELAY_RC_CYCLES)
      << startup_time_fuse; // R21

   // Readback, unused bits zero
   assign sleep_rd = {4'h0, s_r.sleep_ctrl} & spc_pkg::MASK_SLEEP_MODE_CONTROL; // R01
   assign mcu_rd = {1'b0, off_bit, unlock_bit, s_r.mcu_misc[2], 2'b00, s_r.mcu_misc[1:0]};
   assign gate_rd = s_r.gate & spc_pkg::MASK_PERIPHERAL_CLOCK_GATE; // R15

   // Reset sources; pin filter gives the minimum width
   assign ext_req = (s_r.ext_cnt >= EXT_MIN_CYCLES);
   assign bod_req = brownout_detect && s_r.bod_en;
   assign rst_req = por_detect || ext_req || s_r.wdt_pulse || bod_req; // R22 R25
   assign soft_rst = !core_reset_n;

   // Ports reset straight from supply, pin and brown-out; watchdog through its registered pulse
   assign port_reset_n = !(por_detect || !ext_reset_pin_n || s_r.wdt_pulse || bod_req); // R20

   spc_rst_stretch #(
      .CNT_W(CNT_W)
   ) u_stretch (
      .pclk(pclk),
      .presetn(presetn),
      .rst_req(rst_req),
      .delay_cycles(delay_cycles),
      .rst_hold(core_reset_n_hold)
   );

   // Core leaves reset only when the stretch ends
   assign core_reset_n = !core_reset_n_hold; // R19

   spc_brownout_sleep_off_seq u_brownout_sleep_off (
      .pclk(pclk),
      .presetn(presetn),
      .soft_rst(soft_rst),
      .wr_stb(wr_mcu),
      .wr_off(pwdata[spc_pkg::BROWNOUT_SLEEP_OFF_BIT]),
      .wr_unlock(pwdata[spc_pkg::BROWNOUT_SLEEP_UNLOCK_BIT]),
      .off_bit(off_bit),
      .unlock_bit(unlock_bit),
      .off_active(off_active)
   );

   // Registers, sleep sequencer, filters, enables
   always_comb begin
      s_nxt = s_r;
      s_nxt.slverr = 1'b0;

      // Read data and error are taken in the setup cycle
      if (setup_phase) begin
         s_nxt.rdata = 32'h0000_0000;
         s_nxt.slverr = 1'b0;
         unique case (paddr)
            spc_pkg::ADDR_SLEEP_MODE_CONTROL: s_nxt.rdata = {24'h00_0000, sleep_rd};
            spc_pkg::ADDR_MCU_CONTROL: s_nxt.rdata = {24'h00_0000, mcu_rd};
            spc_pkg::ADDR_PERIPHERAL_CLOCK_GATE: s_nxt.rdata = {24'h00_0000, gate_rd};
            default: s_nxt.slverr = 1'b1;
         endcase
      end else begin
         s_nxt.slverr = s_r.slverr;
      end

      // Writes take effect at the access edge
      if (access_wr) begin
         unique case (paddr)
            spc_pkg::ADDR_SLEEP_MODE_CONTROL: s_nxt.sleep_ctrl = pwdata[3:0]; // R01
            spc_pkg::ADDR_MCU_CONTROL: s_nxt.mcu_misc = {pwdata[4], pwdata[1:0]};
            spc_pkg::ADDR_PERIPHERAL_CLOCK_GATE: s_nxt.gate = pwdata[7:0] &
               spc_pkg::MASK_PERIPHERAL_CLOCK_GATE; // R15
            default: s_nxt.gate = s_r.gate;
         endcase
      end

      // Reset pin low-time filter, pin taken as synchronous
      if (!ext_reset_pin_n) begin
         if (s_r.ext_cnt != 8'hFF) begin
            s_nxt.ext_cnt = s_r.ext_cnt + 8'h01;
         end
      end else begin
         s_nxt.ext_cnt = 8'h00;
      end

      // Edge detect keeps the watchdog reset to one cycle even if expiry is held
      s_nxt.wdt_prev = wdt_timeout;
      s_nxt.wdt_pulse = wdt_timeout && !s_r.wdt_prev && wdt_system_mode; // R23

      // Sleep sequencer; watchdog inputs are never masked by sleep
      unique case (s_r.state)
         ST_ACTIVE: begin
            if (sleep_instr && s_r.sleep_ctrl[spc_pkg::SLEEP_ARM_BIT]) begin
               s_nxt.state = ST_ASLEEP; // R03
               s_nxt.mode = spc_pkg::spc_mode_e'(s_r.sleep_ctrl[3:1]);
               s_nxt.bod_off = off_active; // R07
            end
         end
         ST_ASLEEP: begin
            if (wake_event) begin
               s_nxt.state = ST_WAKING;
               if (s_r.mode == spc_pkg::MODE_STANDBY ||
                   s_r.mode == spc_pkg::MODE_EXT_STANDBY) begin
                  s_nxt.wake_cnt = spc_pkg::STANDBY_WAKE_CYCLES - CNT_W'(1); // R24
               end else if (s_r.mode == spc_pkg::MODE_POWER_DOWN ||
                            s_r.mode == spc_pkg::MODE_POWER_SAVE) begin
                  // Stopped oscillator needs the full fuse start-up time
                  s_nxt.wake_cnt = delay_cycles - CNT_W'(1);
               end else begin
                  s_nxt.wake_cnt = '0;
               end
            end
         end
         ST_WAKING: begin
            if (s_r.wake_cnt == '0) begin
               s_nxt.state = ST_ACTIVE;
               s_nxt.bod_off = 1'b0;
            end else begin
               s_nxt.wake_cnt = s_r.wake_cnt - CNT_W'(1);
            end
         end
      endcase

      // Clock enables per mode; reserved codes behave as idle
      s_nxt.clk = '{cpu: 1'b1, io: 1'b1, adc: 1'b1, async_timer: 1'b1, main_osc: 1'b1};
      if (s_r.state != ST_ACTIVE) begin
         s_nxt.clk.cpu = 1'b0;
         unique case (s_r.mode) // R02
            spc_pkg::MODE_IDLE, spc_pkg::MODE_RESERVED_4, spc_pkg::MODE_RESERVED_5: begin
               s_nxt.clk.io = 1'b1;
            end
            spc_pkg::MODE_NOISE_REDUCTION: begin
               s_nxt.clk.io = 1'b0;
            end
            spc_pkg::MODE_POWER_DOWN: begin
               s_nxt.clk = '0;
            end
            spc_pkg::MODE_POWER_SAVE: begin
               s_nxt.clk = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_timer: 1'b1,
                  main_osc: 1'b0};
            end
            spc_pkg::MODE_STANDBY: begin
               s_nxt.clk = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_timer: 1'b0,
                  main_osc: 1'b1};
            end
            spc_pkg::MODE_EXT_STANDBY: begin
               s_nxt.clk = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_timer: 1'b1,
                  main_osc: 1'b1};
            end
         endcase
         // Waking restarts the oscillator before the core resumes
         if (s_r.state == ST_WAKING) begin
            s_nxt.clk.main_osc = 1'b1;
         end
      end
      if (debug_enable_fuse) begin
         s_nxt.clk.main_osc = 1'b1; // R18
      end

      // Wake-detect inputs are outside this gate and stay enabled
      s_nxt.in_buf = s_nxt.clk.io || s_nxt.clk.adc; // R16
      s_nxt.bod_en = brownout_fuse_en && !(s_r.state != ST_ACTIVE && s_r.bod_off); // R07

      // Gating; peripherals keep their frozen state
      s_nxt.periph.two_wire = !s_r.gate[spc_pkg::TWO_WIRE_GATE_BIT] && s_nxt.clk.io; // R09
      s_nxt.periph.timer_two = !(s_r.gate[spc_pkg::TIMER_TWO_GATE_BIT] &&
         !timer_two_async_select); // R10
      s_nxt.periph.timer_zero = !s_r.gate[spc_pkg::TIMER_ZERO_GATE_BIT] && s_nxt.clk.io; // R11
      s_nxt.periph.timer_one = !s_r.gate[spc_pkg::TIMER_ONE_GATE_BIT] && s_nxt.clk.io; // R11
      s_nxt.periph.serial_periph = !s_r.gate[spc_pkg::SERIAL_PERIPH_GATE_BIT] &&
         s_nxt.clk.io; // R12
      s_nxt.periph.serial_port = !s_r.gate[spc_pkg::SERIAL_PORT_GATE_BIT] && s_nxt.clk.io; // R13
      s_nxt.periph.converter_powered = !s_r.gate[spc_pkg::CONVERTER_GATE_BIT]; // R14
      s_nxt.periph.comparator_mux = !s_r.gate[spc_pkg::CONVERTER_GATE_BIT]; // R14

      // Internal reset restores initial values
      if (soft_rst) begin
         s_nxt.sleep_ctrl = spc_pkg::RST_SLEEP_MODE_CONTROL[3:0]; // R19
         s_nxt.mcu_misc = 3'h0;
         s_nxt.gate = spc_pkg::RST_PERIPHERAL_CLOCK_GATE;
         s_nxt.state = ST_ACTIVE;
         s_nxt.mode = spc_pkg::MODE_IDLE;
         s_nxt.bod_off = 1'b0;
         s_nxt.wake_cnt = '0;
      end
   end

   // Initial register contents
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{sleep_ctrl: 4'h0, mcu_misc: 3'h0, gate: 8'h00, rdata: 32'h0000_0000,
            slverr: 1'b0, state: ST_ACTIVE, mode: spc_pkg::MODE_IDLE, bod_off: 1'b0,
            wake_cnt: '0, ext_cnt: 8'h00, wdt_prev: 1'b0, wdt_pulse: 1'b0,
            clk: '1, periph: '1, in_buf: 1'b1, bod_en: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Registered outputs
   assign cpu_asleep = (s_r.state != ST_ACTIVE); // R03
   assign brownout_detector_en = s_r.bod_en;
   assign input_buf_en = s_r.in_buf;
   assign clk_en = s_r.clk; // R17
   assign periph_en = s_r.periph;
endmodule

/* File: spc_power_ctrl_properties.sv */
// Assertions of the power controller
`timescale 1ns/1ns
module spc_power_ctrl_properties (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] prdata, // Read data
   input wire logic sleep_instr, // Sleep request
   input wire logic debug_enable_fuse, // Debug
   input wire logic por_detect, // Supply low
   input wire logic wdt_timeout, // Watchdog
   input wire logic wdt_system_mode, // Watchdog mode
   input wire logic port_reset_n, // Port reset
   input wire logic core_reset_n, // Core reset
   input wire logic cpu_asleep, // Asleep
   input wire spc_pkg::spc_clk_en_s clk_en // Clocks
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Read in its access cycle
   wire logic rd = psel && penable && !pwrite;
   a_sleep_upper: assert property (rd && paddr == spc_pkg::ADDR_SLEEP_MODE_CONTROL
      |-> prdata[31:4] == 28'h000_0000) else $error("sleep control upper bits set");
   a_gate_rsvd: assert property (rd && paddr == spc_pkg::ADDR_PERIPHERAL_CLOCK_GATE
      |-> !prdata[4]) else $error("reserved gate bit set");
   a_port_rst: assert property (por_detect |-> !port_reset_n)
      else $error("port reset late");
   a_core_hold: assert property (por_detect |=> !core_reset_n)
      else $error("core reset not held");
   // Ports were free well before release
   a_stretch_len: assert property ($rose(core_reset_n) |-> $past(port_reset_n, 8))
      else $error("reset stretch too short");
   a_wdt_pulse: assert property ($rose(wdt_timeout) && wdt_system_mode
      |-> ##[1:3] !core_reset_n) else $error("watchdog reset missing");
   a_sleep_cause: assert property ($rose(cpu_asleep) |-> $past(sleep_instr))
      else $error("sleep without instruction");
   a_sleep_cpu: assert property ($rose(cpu_asleep) |=> !clk_en.cpu)
      else $error("cpu clock runs in sleep");
   a_debug_osc: assert property (debug_enable_fuse && cpu_asleep |-> clk_en.main_osc)
      else $error("main clock stopped");
   c_sleep: cover property ($rose(cpu_asleep));
   c_reset: cover property ($fell(core_reset_n));
   c_wdt: cover property ($rose(wdt_timeout) && wdt_system_mode);
endmodule
bind spc_power_ctrl spc_power_ctrl_properties u_props (.*);

/* File: spc_core_model.sv */
// Core model: sleep instructions and wake requests
`timescale 1ns/1ns
module spc_core_model (
   input wire logic pclk, // Clock
   input wire logic go, // Execute one sleep
   input wire logic wake, // Start a wake-up
   input wire logic cpu_asleep, // Core held
   output logic sleep_instr, // Sleep pulse
   output logic wake_event // Wake level
);
   // One-cycle instruction
   always_ff @(posedge pclk) sleep_instr <= go;
   // Wake level holds until the core runs
   always_ff @(posedge pclk) wake_event <= wake || (wake_event && cpu_asleep);
endmodule

/* File: spc_power_ctrl_test.sv */
// Bench of the power and reset controller
`timescale 1ns/1ns
module spc_power_ctrl_test;
   localparam logic [11:0] smc_a = spc_pkg::ADDR_SLEEP_MODE_CONTROL;
   localparam logic [11:0] mcu_a = spc_pkg::ADDR_MCU_CONTROL;
   localparam logic [11:0] gate_a = spc_pkg::ADDR_PERIPHERAL_CLOCK_GATE;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic go, wake, sleep_instr, wake_event, t2_async, por, pin_n, wdt, wdt_sys, bo, bo_en;
   logic port_reset_n, core_reset_n, cpu_asleep, bo_det_en, buf_en;
   spc_pkg::spc_clk_en_s clk_en;
   spc_pkg::spc_periph_s periph_en;
   int err_count, cmp_count, n;
   // Short delays keep the reset stretch at 16 cycles
   spc_power_ctrl #(.DELAY_RC_CYCLES(24'h00_0010), .DELAY_XTAL_CYCLES(24'h00_0020)) DUT (
      .*, .timer_two_async_select(t2_async),
      .debug_enable_fuse(1'b1), .startup_time_fuse(2'h0), .clock_select_fuse(4'h0),
      .por_detect(por), .ext_reset_pin_n(pin_n), .wdt_timeout(wdt),
      .wdt_system_mode(wdt_sys), .brownout_detect(bo), .brownout_fuse_en(bo_en),
      .brownout_detector_en(bo_det_en), .input_buf_en(buf_en));
   spc_core_model u_core (.*);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         err_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, g, x);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         err_count++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, x);
   endtask
   // Wait for 0 asleep, 1 awake, 2 out of reset; n counts
   task automatic wt(input int k);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (n < 200 && (k == 0 ? cpu_asleep : k == 1 ? !cpu_asleep : core_reset_n) !== 1'b1);
      if (n == 200) begin
         err_count++;
         stop_test();
      end
   endtask
   // Core model request: sleep or wake
   task automatic poke(input logic s);
      @(posedge pclk);
      if (s) go <= 1'b1;
      else wake <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      wake <= 1'b0;
   endtask
   task automatic t_regs();
      logic [11:0] a [3] = '{smc_a, mcu_a, gate_a};
      foreach (a[i]) rd(a[i], 32'h0000_0000);
      wr(smc_a, 32'h0000_009F);
      rd(smc_a, 32'h0000_000F);
      wr(gate_a, 32'h0000_009F);
      rd(gate_a, 32'h0000_008F);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      foreach (a[i]) wr(a[i], 32'h0000_0000);
      $display("register test done");
   endtask
   task automatic gate(input logic [7:0] v, input logic [7:0] x);
      wr(gate_a, {24'h00_0000, v});
      repeat (2) @(negedge pclk);
      chk({24'h00_0000, periph_en}, {24'h00_0000, x});
   endtask
   task automatic t_gates();
      int b [7] = '{7, 6, 5, 3, 2, 1, 0};
      logic [7:0] x;
      foreach (b[i]) begin
         x = 8'hFF & ~(8'h80 >> i);
         if (i == 6) x[0] = 1'b0;
         gate(8'h01 << b[i], x);
      end
      @(posedge pclk) t2_async <= 1'b1;
      gate(8'h40, 8'hFF);
      @(posedge pclk) t2_async <= 1'b0;
      gate(8'h00, 8'hFF);
      $display("gate test done");
   endtask
   task automatic t_sleep();
      logic io, adc;
      wr(smc_a, 32'h0000_0004);
      poke(1'b1);
      repeat (4) @(negedge pclk);
      chk({31'h0000_0000, cpu_asleep}, 32'h0000_0000);
      for (int m = 0; m < 8; m++) begin
         io = (m == 0 || m == 4 || m == 5);
         adc = io || m == 1;
         wr(smc_a, 32'(m * 2 + 1));
         poke(1'b1);
         wt(0);
         repeat (2) @(negedge pclk);
         chk({clk_en.cpu, clk_en.io, buf_en, bo_det_en}, {1'b0, io, adc, 1'b1});
         poke(1'b0);
         wt(1);
         chk(32'(m > 5 ? n <= 10 : (m == 2 || m == 3) ? n >= 14 : 1), 32'h0000_0001);
         wr(smc_a, 32'h0000_0000);
      end
      $display("sleep test done");
   endtask
   task automatic t_brownout_sleep_off();
      wr(smc_a, 32'h0000_0005);
      wr(mcu_a, 32'h0000_0060);
      wr(mcu_a, 32'h0000_0040);
      repeat (2) @(posedge pclk);
      poke(1'b1);
      wt(0);
      repeat (2) @(negedge pclk);
      chk({31'h0000_0000, bo_det_en}, 32'h0000_0000);
      poke(1'b0);
      wt(1);
      rd(mcu_a, 32'h0000_0000);
      chk({31'h0000_0000, bo_det_en}, 32'h0000_0001);
      wr(smc_a, 32'h0000_0000);
      $display("brownout test done");
   endtask
   // Source k (supply, pin, watchdog, brownout) on for len cycles
   task automatic src(input int k, input int len);
      @(posedge pclk);
      por <= k == 0;
      pin_n <= k != 1;
      wdt <= k == 2;
      bo <= k == 3;
      @(negedge pclk) if (k != 2) chk({31'h0000_0000, port_reset_n}, 32'h0000_0000);
      repeat (len) @(posedge pclk);
      {por, wdt, bo, pin_n} <= 4'h1;
   endtask
   task automatic t_resets();
      wr(gate_a, 32'h0000_0001);
      src(0, 3);
      repeat (8) @(posedge pclk);
      src(0, 2);
      wt(2);
      chk(32'(n >= 15 && n <= 20), 32'h0000_0001);
      rd(gate_a, 32'h0000_0000);
      src(1, 2);
      repeat (3) @(negedge pclk);
      chk({31'h0000_0000, core_reset_n}, 32'h0000_0001);
      for (int k = 1; k < 4; k++) begin
         src(k, 6);
         @(negedge pclk);
         chk({31'h0000_0000, core_reset_n}, 32'h0000_0000);
         wt(2);
      end
      $display("reset test done");
   endtask
   initial begin
      {presetn, psel, penable, pwrite, go, wake, t2_async, por, wdt, bo} = 10'h000;
      {pin_n, wdt_sys, bo_en} = 3'h7;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      err_count = 0;
      cmp_count = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wt(2);
      t_regs();
      t_gates();
      t_sleep();
      t_brownout_sleep_off();
      t_resets();
      stop_test();
   end
endmodule
